/* File: rtl/asp_pkg.sv */
package asp_pkg;

  // Peripheral number on the configuration access path.
  localparam logic [7:0]  PERIPH_NUM        = 8'h02;

  // Register byte offsets.
  localparam logic [7:0]  OFF_PIN0          = 8'h00;
  localparam logic [7:0]  OFF_PIN1          = 8'h04;
  localparam logic [7:0]  OFF_PIN2          = 8'h08;
  localparam logic [7:0]  OFF_PIN3          = 8'h0c;
  localparam logic [7:0]  OFF_GEN           = 8'h20;

  // Field positions.
  localparam int          PIN_EN_BIT        = 0;
  localparam int          PIN_DEST_LSB      = 8;
  localparam int          GEN_ENABLE_BIT    = 0;
  localparam int          GEN_CAL_BIT       = 1;
  localparam int          GEN_SPP_LSB       = 8;
  localparam int          GEN_WIDTH_LSB     = 16;
  localparam int          GEN_DROP_BIT      = 24;

  // Reset values.
  localparam logic [31:0] PIN_RESET         = 32'h0000_0000;
  localparam logic [1:0]  WIDTH_RESET       = 2'h1;
  localparam logic [7:0]  SPP_RESET         = 8'h01;
  localparam logic        DROP_RESET        = 1'b1;

  // Sample width encodings.
  localparam logic [1:0]  WIDTH_8           = 2'h0;
  localparam logic [1:0]  WIDTH_16          = 2'h1;
  localparam logic [1:0]  WIDTH_32          = 2'h3;

  // Start-up calibration pulse count after each enable.
  localparam logic [2:0]  CAL_PULSES        = 3'h6;

  localparam int          NUM_PINS          = 4;

  // Configuration access request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  periph;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } asp_cfg_req_s;

  // One byte toward the message network.
  typedef struct packed {
    logic        valid;
    logic        header;
    logic        last;
    logic [23:0] dest;
    logic [7:0]  data;
  } asp_tx_s;

endpackage : asp_pkg

/* File: rtl/asp_packetizer.sv */
`timescale 1ns/10ps
// How it works
// - Each trigger rising edge that finds the converter idle takes one 12-bit result from the next scanned pin.
// - Pin control bits 31:8 hold the destination identifier used for its samples.
// - Pin control bit 0 enables sampling of that pin; cleared pins are skipped.
// - Registers are full 32-bit words answered only for peripheral number 2.
// - General bit 24 flags a lost sample and clears on a general read.
// - The 12-bit result is left-aligned in the sample word at every width.
// - Width 0 gives 8 bits, 1 gives 16, 3 gives 32, 2 is reserved.
// - Wider samples go out most significant byte first.
// - Samples-per-packet field closes the packet after that many samples.
// - Samples-per-packet zero keeps the packet open until a register access or a change of pin.
// - General bit 1 switches the converter input to the internal 0.8V reference.
// - General bit 0 enables the converter and makes pin words read-only.
// - The six calibration pulses after enabling produce no packets.
// - From the seventh pulse onward each sample goes to its destination.
// - Calibration phase restarts on every enable rise from 0 to 1.
module asp_packetizer
  import asp_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         trig_clk,
  input  wire asp_cfg_req_s cfg_req,
  output logic [31:0]       cfg_rdata,
  output logic              cfg_ack,
  output logic              conv_start,
  output logic [1:0]        conv_pin,
  output logic              conv_enable,
  output logic              conv_cal_ref,
  input  wire logic         conv_done,
  input  wire logic [11:0]  conv_result,
  output asp_tx_s           tx,
  input  wire logic         tx_ready
);

  typedef enum logic [1:0] {ST_IDLE, ST_HEAD, ST_DATA, ST_END} asp_tx_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [31:0]     pin_ctrl [NUM_PINS];
  logic            gen_enable;
  logic            gen_cal;
  logic [7:0]      gen_spp;
  logic [1:0]      gen_width;
  logic            gen_drop;
  logic [2:0]      trig_sync;
  logic [2:0]      cal_cnt;
  logic [1:0]      scan_pin;
  logic            scan_busy;
  logic [1:0]      res_pin;
  logic [11:0]     res_data;
  logic            res_full;
  asp_tx_state_e   state;
  logic [1:0]      byte_idx;
  logic [7:0]      spp_cnt;
  logic            pkt_open;
  logic [1:0]      pkt_pin;
  logic [31:0]     shreg;
  logic            close_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Next enabled pin after the given one, wrapping round.
  function automatic logic [1:0] asp_next_pin(input logic [1:0] cur, input logic [NUM_PINS-1:0] en);
    logic [1:0] r;
    logic [2:0] k;
    r = cur;
    for (int i = NUM_PINS; i >= 1; i--) begin
      k = 3'(cur) + 3'(i);
      if (en[k[1:0]]) begin
        r = k[1:0];
      end
    end
    return r;
  endfunction : asp_next_pin

  // Index of the last byte of one sample for a width code.
  function automatic logic [1:0] asp_last_byte(input logic [1:0] w);
    logic [1:0] r;
    r = 2'h0;
    case (w)
      WIDTH_16: r = 2'h1;
      WIDTH_32: r = 2'h3;
      default:  r = 2'h0;
    endcase
    return r;
  endfunction : asp_last_byte

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  // Register access decode.
  wire             acc_hit    = cfg_req.valid && (cfg_req.periph == PERIPH_NUM);
  wire             wr_hit     = acc_hit && cfg_req.write;
  wire             rd_gen     = acc_hit && !cfg_req.write && (cfg_req.addr == OFF_GEN);
  wire             wr_gen     = wr_hit && (cfg_req.addr == OFF_GEN);
  wire             pin_wr_ok  = wr_hit && !gen_enable;
  wire [NUM_PINS-1:0] pin_en  = {pin_ctrl[3][PIN_EN_BIT], pin_ctrl[2][PIN_EN_BIT],
                                 pin_ctrl[1][PIN_EN_BIT], pin_ctrl[0][PIN_EN_BIT]};

  // Trigger and converter decode. A trigger that finds the converter busy is lost on purpose:
  // queueing it would skew the sample spacing that the trigger port sets.
  wire             trig_rise  = trig_sync[1] && !trig_sync[2];
  wire             in_cal     = cal_cnt != CAL_PULSES;
  wire             en_rise    = wr_gen && cfg_req.wdata[GEN_ENABLE_BIT] && !gen_enable;
  wire             start_conv = trig_rise && gen_enable && (pin_en != '0) && !scan_busy;
  wire             deliver    = conv_done && scan_busy && !in_cal;
  wire [1:0]       next_pin   = asp_next_pin(scan_pin, pin_en);

  // Sender decode.
  wire [1:0]       last_byte  = asp_last_byte(gen_width);
  wire             tx_go      = tx.valid && tx_ready;
  // An access closes any open packet; with a zero count only an access or a change of pin ends it.
  wire             close_req  = (acc_hit || close_pend) && pkt_open;
  wire             spp_done   = (gen_spp != 8'h00) && (spp_cnt == gen_spp);
  // While a packet is being closed the waiting sample must stay in its slot, or it is lost silently.
  wire             close_now  = close_req || (pkt_open && spp_done) ||
                                (pkt_open && res_full && (res_pin != pkt_pin));
  wire             res_take   = (state == ST_IDLE) && res_full && !close_now;
  wire             drop_evt   = deliver && res_full && !res_take;

  assign conv_enable  = gen_enable;
  assign conv_cal_ref = gen_cal;
  assign cfg_ack      = acc_hit;

  // Sample word, left-aligned at every width.
  // Width 2 is reserved and sends one byte, as width 0 does.
  wire [31:0]      sample_word = {res_data, 20'h00000};

  ////////////////////////////////////////////////////////////////////////////
  // Read data: reserved bits read as zero.
  // The general word is assembled field by field so that reserved bits can never leak out.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (cfg_req.addr)
      OFF_PIN0: rd_mux = pin_ctrl[0] & 32'hffff_ff01;
      OFF_PIN1: rd_mux = pin_ctrl[1] & 32'hffff_ff01;
      OFF_PIN2: rd_mux = pin_ctrl[2] & 32'hffff_ff01;
      OFF_PIN3: rd_mux = pin_ctrl[3] & 32'hffff_ff01;
      OFF_GEN: begin
        rd_mux[GEN_DROP_BIT]                    = gen_drop;
        rd_mux[GEN_WIDTH_LSB+1:GEN_WIDTH_LSB]   = gen_width;
        rd_mux[GEN_SPP_LSB+7:GEN_SPP_LSB]       = gen_spp;
        rd_mux[GEN_CAL_BIT]                     = gen_cal;
        rd_mux[GEN_ENABLE_BIT]                  = gen_enable;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is registered; unmapped offsets read zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (acc_hit && !cfg_req.write) begin
      cfg_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin control words, frozen while the converter is enabled.
  // Only word-aligned offsets in the first sixteen bytes reach a pin word.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_ctrl[i] <= PIN_RESET;
      end
    end else if (pin_wr_ok && (cfg_req.addr[7:4] == 4'h0) && (cfg_req.addr[1:0] == 2'h0)) begin
      pin_ctrl[cfg_req.addr[3:2]] <= cfg_req.wdata & 32'hffff_ff01;
    end
  end

  // General control fields.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gen_enable <= 1'b0;
      gen_cal    <= 1'b0;
      gen_spp    <= SPP_RESET;
      gen_width  <= WIDTH_RESET;
    end else if (wr_gen) begin
      gen_enable <= cfg_req.wdata[GEN_ENABLE_BIT];
      gen_cal    <= cfg_req.wdata[GEN_CAL_BIT];
      gen_spp    <= cfg_req.wdata[GEN_SPP_LSB+7:GEN_SPP_LSB];
      gen_width  <= cfg_req.wdata[GEN_WIDTH_LSB+1:GEN_WIDTH_LSB];
    end
  end

  // Dropped flag: a drop in the same cycle as the read wins over the clear.
  // Reads of any other word leave the flag alone.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gen_drop <= DROP_RESET;
    end else if (drop_evt) begin
      gen_drop <= 1'b1;
    end else if (rd_gen) begin
      gen_drop <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger synchroniser; only stages two and three feed the edge detector.
  // All stages reset to the idle low level, so no false edge follows reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_sync <= 3'h0;
    end else begin
      trig_sync <= {trig_sync[1:0], trig_clk};
    end
  end

  // Calibration pulse counter, restarted on each enable rise.
  // Counting finished conversions rather than edges keeps triggers lost while busy out of the count.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_cnt <= 3'h0;
    end else if (en_rise) begin
      cal_cnt <= 3'h0;
    end else if (conv_done && scan_busy && in_cal) begin
      cal_cnt <= cal_cnt + 3'h1;
    end
  end

  // Scan sequencer: one conversion per trigger edge, next enabled pin each time.
  // Triggers arriving mid-conversion are ignored; the converter cannot take them.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_pin   <= 2'h3;
      scan_busy  <= 1'b0;
      conv_start <= 1'b0;
      conv_pin   <= 2'h0;
    end else begin
      conv_start <= start_conv;
      if (start_conv) begin
        scan_pin  <= next_pin;
        conv_pin  <= next_pin;
        scan_busy <= 1'b1;
      end else if (conv_done || !gen_enable) begin
        scan_busy <= 1'b0;
      end
    end
  end

  // Result holding slot; a new result overwrites an unsent one.
  // The slot is released only when the sender really takes the sample.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      res_full <= 1'b0;
      res_data <= 12'h000;
      res_pin  <= 2'h0;
    end else if (deliver) begin
      res_full <= 1'b1;
      res_data <= conv_result;
      res_pin  <= conv_pin;
    end else if (res_take) begin
      res_full <= 1'b0;
    end
  end

  // An access that arrives while a sample is going out is remembered, so a zero-count packet still ends.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      close_pend <= 1'b0;
    end else if (state == ST_END) begin
      close_pend <= 1'b0;
    end else if (acc_hit && pkt_open) begin
      close_pend <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet sender. A header byte slot opens a packet to a pin's destination;
  // a change of pin closes the current packet first.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      byte_idx <= 2'h0;
      spp_cnt  <= 8'h00;
      pkt_open <= 1'b0;
      pkt_pin  <= 2'h0;
      shreg    <= 32'h0000_0000;
    end else begin
      case (state)
        // Closing comes first; a waiting sample stays in its slot for the next packet.
        ST_IDLE: begin
          if (close_now) begin
            state <= ST_END;
          end else if (res_full) begin
            shreg    <= sample_word;
            byte_idx <= 2'h0;
            state    <= pkt_open ? ST_DATA : ST_HEAD;
            pkt_pin  <= pkt_open ? pkt_pin : res_pin;
          end
        end
        // Header slot: the destination stands on the bus until the receiver takes it.
        ST_HEAD: begin
          if (tx_go) begin
            pkt_open <= 1'b1;
            spp_cnt  <= 8'h00;
            state    <= ST_DATA;
          end
        end
        // One byte per acceptance, top byte first.
        ST_DATA: begin
          if (tx_go) begin
            shreg    <= {shreg[23:0], 8'h00};
            byte_idx <= byte_idx + 2'h1;
            if (byte_idx == last_byte) begin
              spp_cnt <= spp_cnt + 8'h01;
              state   <= ST_IDLE;
            end
          end
        end
        // End slot: the packet counts as closed once the receiver takes it.
        ST_END: begin
          if (tx_go) begin
            pkt_open <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Byte stream toward the channel network.
  // Every field comes from a register, so only a pin word written while the converter is disabled can move data under a held slot.
  always_comb begin
    tx        = '0;
    tx.valid  = (state != ST_IDLE);
    tx.header = (state == ST_HEAD);
    tx.last   = (state == ST_END);
    tx.dest   = pin_ctrl[pkt_pin][31:PIN_DEST_LSB];
    tx.data   = shreg[31:24];
  end

endmodule : asp_packetizer

/* File: verification/asp_checker.sv */
`timescale 1ns/10ps
module asp_checker
  import asp_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         rst,
  input wire logic         trig_clk,
  input wire asp_cfg_req_s cfg_req,
  input wire logic [31:0]  cfg_rdata,
  input wire logic         cfg_ack,
  input wire logic         conv_start,
  input wire logic [1:0]   conv_pin,
  input wire logic         conv_enable,
  input wire logic         conv_cal_ref,
  input wire logic         conv_done,
  input wire logic [11:0]  conv_result,
  input wire asp_tx_s      tx,
  input wire logic         tx_ready
);
  logic acc;
  logic gen_wr;
  logic gen_rd;
  logic pin_rd;
  logic in_pkt;

  // Decoded accesses; reads compare against state one edge back.
  assign acc    = cfg_req.valid && cfg_req.periph == PERIPH_NUM;
  assign gen_wr = acc && cfg_req.write && cfg_req.addr == OFF_GEN;
  assign gen_rd = acc && !cfg_req.write && cfg_req.addr == OFF_GEN;
  assign pin_rd = acc && !cfg_req.write && cfg_req.addr[7:4] == 4'h0;

  // Tracks whether a header has been taken and no end slot since.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_pkt <= 1'b0;
    end else if (tx.valid && tx_ready && (tx.header || tx.last)) begin
      in_pkt <= tx.header;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ack_decode: assert property (cfg_ack == acc) else $error("ack decode");
  a_enable_write: assert property (gen_wr |=> conv_enable == $past(cfg_req.wdata[0])) else $error("enable");
  a_cal_write: assert property (gen_wr |=> conv_cal_ref == $past(cfg_req.wdata[1])) else $error("cal");
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start width");
  a_start_enabled: assert property (conv_start |-> $past(conv_enable)) else $error("start off");
  a_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx)) else $error("tx hold");
  a_gen_fields: assert property (gen_rd |=> cfg_rdata[31:25] == 7'h00 && cfg_rdata[23:18] == 6'h00
    && cfg_rdata[1:0] == {$past(conv_cal_ref), $past(conv_enable)}) else $error("gen read");
  a_pin_reserved: assert property (pin_rd |=> cfg_rdata[7:1] == 7'h00) else $error("pin read");
  a_slot_order: assert property (tx.valid |-> (tx.header ? !in_pkt : in_pkt)) else $error("slot order");

  c_start: cover property (conv_start);
  c_close: cover property (tx.valid && tx.last && tx_ready);
  c_gen_rd: cover property (gen_rd);
endmodule : asp_checker

bind asp_packetizer asp_checker chk (.clk_sys(clk_sys), .rst(rst), .trig_clk(trig_clk), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .conv_start(conv_start), .conv_pin(conv_pin),
  .conv_enable(conv_enable), .conv_cal_ref(conv_cal_ref), .conv_done(conv_done),
  .conv_result(conv_result), .tx(tx), .tx_ready(tx_ready));

/* File: verification/asp_rx_model.sv */
`timescale 1ns/10ps
module asp_rx_model
  import asp_pkg::*;
(
  input wire logic    clk_sys,
  input wire logic    rst,
  input wire asp_tx_s tx,
  input wire logic    stall,
  input wire logic    slow,
  output logic        tx_ready
);
  asp_tx_s q[$];
  logic    ph;

  // Receiver takes a slot on each handshake; slow mode halves the rate to expose holding bugs.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph       <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      if (tx.valid && tx_ready)
        q.push_back(tx);
      ph       <= !ph;
      tx_ready <= #1 !stall && (ph || !slow);
    end
  end
endmodule : asp_rx_model

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top
  import asp_pkg::*;
();
  logic         clk_sys, rst, trig_clk, conv_done, stall, slow;
  logic         cfg_ack, conv_start, conv_enable, conv_cal_ref, tx_ready;
  logic [1:0]   conv_pin;
  logic [11:0]  conv_result;
  logic [31:0]  cfg_rdata;
  asp_cfg_req_s cfg_req;
  asp_tx_s      tx;
  int           n_errors, checked;

  asp_packetizer dut (.clk_sys(clk_sys), .rst(rst), .trig_clk(trig_clk), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .conv_start(conv_start), .conv_pin(conv_pin),
    .conv_enable(conv_enable), .conv_cal_ref(conv_cal_ref), .conv_done(conv_done),
    .conv_result(conv_result), .tx(tx), .tx_ready(tx_ready));
  asp_rx_model rx (.clk_sys(clk_sys), .rst(rst), .tx(tx), .stall(stall), .slow(slow), .tx_ready(tx_ready));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Converter stand-in: result top byte fixed, low bits name the pin, so alignment shows.
  initial begin
    conv_done = 1'b0;
    conv_result = 12'h000;
    forever begin
      @(posedge clk_sys);
      #1;
      if (conv_start === 1'b1) begin
        repeat (3) @(posedge clk_sys);
        #1 conv_result = {8'h9c, 2'h0, conv_pin};
        conv_done = 1'b1;
        @(posedge clk_sys);
        #1 conv_done = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // One access; the request is held across the edge that takes it.
  task automatic bus(input logic [7:0] pe, input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1 cfg_req = '{1'b1, w, pe, a, d};
    @(posedge clk_sys);
    #1 cfg_req.valid = 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(PERIPH_NUM, 1'b0, a, 32'h0000_0000);
    chk(cfg_rdata, e);
  endtask : rd

  function automatic logic [31:0] gen(input logic en, input logic cal, input logic [7:0] spp, input logic [1:0] w);
    return {14'h0000, w, spp, 6'h00, cal, en};
  endfunction : gen

  // The trigger is a slow level; gaps are long so no trigger falls on a busy conversion.
  task automatic trig(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 trig_clk = 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 trig_clk = 1'b0;
      repeat (40) @(posedge clk_sys);
    end
  endtask : trig

  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 400 && rx.q.size() < n; i++)
      @(posedge clk_sys);
    if (rx.q.size() < n) begin
      n_errors++;
      final_report();
    end
  endtask : wait_rx

  // Checks a packet of ns samples of nb bytes each, with or without its end slot.
  task automatic pkt(input logic [23:0] d, input logic [1:0] p, input int ns, input int nb, input logic cl);
    int i;
    int k;
    wait_rx(1 + ns * nb + cl);
    chk(rx.q.size(), 1 + ns * nb + cl);
    chk(rx.q[0].header, 1'b1);
    chk(rx.q[0].dest, d);
    for (i = 0; i < ns * nb; i++) begin
      k = i % nb;
      chk(rx.q[1 + i].data, k == 0 ? 8'h9c : k == 1 ? {2'h0, p, 4'h0} : 8'h00);
    end
    chk(rx.q[rx.q.size() - 1].last, cl);
    rx.q.delete();
  endtask : pkt

  ////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    rd(OFF_PIN0, PIN_RESET);
    rd(OFF_PIN3, PIN_RESET);
    rd(OFF_GEN, 32'h0101_0100);
    rd(OFF_GEN, 32'h0001_0100);
    rd(8'h10, 32'h0000_0000);
    bus(8'h03, 1'b1, OFF_PIN0, 32'hffff_ff01);
    rd(OFF_PIN0, PIN_RESET);
  endtask : s_reset

  task automatic s_scan();
    bus(PERIPH_NUM, 1'b1, OFF_PIN0, 32'habc1_2301);
    bus(PERIPH_NUM, 1'b1, OFF_PIN2, 32'h00c0_de01);
    rd(OFF_PIN0, 32'habc1_2301);
    bus(PERIPH_NUM, 1'b1, OFF_GEN, gen(1'b1, 1'b0, 8'h01, WIDTH_16));
    bus(PERIPH_NUM, 1'b1, OFF_PIN3, 32'h1234_5601);
    rd(OFF_PIN3, PIN_RESET);
    trig(6);
    chk(rx.q.size(), 0);
    trig(1);
    pkt(24'habc123, 2'h0, 1, 2, 1'b1);
    trig(1);
    pkt(24'h00c0de, 2'h2, 1, 2, 1'b1);
    trig(1);
    pkt(24'habc123, 2'h0, 1, 2, 1'b1);
  endtask : s_scan

  task automatic s_width();
    bus(PERIPH_NUM, 1'b1, OFF_GEN, gen(1'b0, 1'b0, 8'h01, WIDTH_16));
    bus(PERIPH_NUM, 1'b1, OFF_PIN2, 32'h0000_0000);
    bus(PERIPH_NUM, 1'b1, OFF_GEN, gen(1'b1, 1'b1, 8'h02, WIDTH_32));
    trig(6);
    chk(rx.q.size(), 0);
    // The first sample after the switch into calibration is the one a receiver drops; its format is still checked.
    trig(2);
    pkt(24'habc123, 2'h0, 2, 4, 1'b1);
  endtask : s_width

  task automatic s_open();
    bus(PERIPH_NUM, 1'b1, OFF_GEN, gen(1'b0, 1'b0, 8'h00, WIDTH_8));
    bus(PERIPH_NUM, 1'b1, OFF_GEN, gen(1'b1, 1'b0, 8'h00, WIDTH_8));
    slow = 1'b0;
    trig(7);
    pkt(24'habc123, 2'h0, 1, 1, 1'b0);
    bus(PERIPH_NUM, 1'b0, OFF_GEN, 32'h0000_0000);
    wait_rx(1);
    chk(rx.q[0].last, 1'b1);
    rx.q.delete();
  endtask : s_open

  task automatic s_drop();
    rd(OFF_GEN, gen(1'b1, 1'b0, 8'h00, WIDTH_8));
    stall = 1'b1;
    trig(3);
    bus(PERIPH_NUM, 1'b0, OFF_GEN, 32'h0000_0000);
    chk(cfg_rdata[24], 1'b1);
    rd(OFF_GEN, gen(1'b1, 1'b0, 8'h00, WIDTH_8));
    stall = 1'b0;
  endtask : s_drop

  initial begin
    rst = 1'b1;
    trig_clk = 1'b0;
    cfg_req = '0;
    stall = 1'b0;
    slow = 1'b1;
    n_errors = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    s_reset();
    s_scan();
    s_width();
    s_open();
    s_drop();
    final_report();
  end
endmodule : tb_top
